// >>> common/mas_regs.svh
// Purpose: register map, field positions, reset values and timing counts of the master axis scaling block
// Assumes: 32-bit avalon-mm slave, byte addresses, one aligned word per register
// Notes:   definitions only
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

// ==========================================================
// register byte offsets
`define MAS_ADDR_W          5
`define MAS_OFS_SOURCE      5'h00
`define MAS_OFS_NUMERATOR   5'h04
`define MAS_OFS_DENOMINATOR 5'h08
`define MAS_OFS_STATUS      5'h0C
`define MAS_OFS_WHOLE_REV   5'h10
`define MAS_OFS_FRACTION    5'h14
`define MAS_OFS_USER_POS    5'h18
`define MAS_OFS_FLAG_SET    5'h1C

// ==========================================================
// fields
`define MAS_SRC_SEL_LSB     0
`define MAS_SRC_ABS_MODE    4
`define MAS_STAT_ABS_OK     0
`define MAS_STAT_HOME_SET   1
`define MAS_STAT_BUSY       2

// ==========================================================
// reset values and limits
`define MAS_RST_SOURCE      2'h1
`define MAS_RST_NUMERATOR   16'h0001
`define MAS_RST_DENOMINATOR 16'h0001
`define MAS_SRC_MIN         2'h1
`define MAS_SRC_MAX         2'h3
`define MAS_WRAP_HI         16'hC000
`define MAS_WRAP_LO         16'h4000
`define MAS_DIV_STEPS       7'h40

`endif

// >>> common/mas_pkg.sv
// Purpose: types shared by the master axis scaling block
// Assumes: mas_regs.svh holds the numbers
// Notes:   none
package mas_pkg;

	typedef enum logic [0:0] {
		MAS_DIV_IDLE,
		MAS_DIV_RUN
	} mas_div_state_type;

	typedef struct packed {
		logic [2:0][15:0]  sync1;
		logic [2:0][15:0]  sync2;
		logic [1:0]        source_sel;
		logic              abs_mode;
		logic signed [15:0] numerator;
		logic [15:0]       denominator;
		logic              abs_ok;
		logic              home_set;
		logic              frac_valid;
		logic [1:0]        frac_fill;
		logic [15:0]       fraction;
		logic signed [31:0] whole_rev;
		mas_div_state_type div_state;
		logic [6:0]        div_count;
		logic              div_neg;
		logic [63:0]       div_quot;
		logic [16:0]       div_rem;
		logic [15:0]       div_den;
		logic [31:0]       user_pos;
		logic              waitrequest;
		logic [31:0]       readdata;
	} mas_state_type;

endpackage

// >>> logic/mas_master_scaling.sv
// Purpose: master axis position tracking and scaling into master user units
// Assumes: fraction inputs come from feedback modules in three option slots, asynchronous to mclk
// Notes:   user position is signed 16.16 user units, refreshed every 65 clocks
//
// The register addresses and the Avalon-MM slave port were decided locally.
`include "mas_regs.svh"

// Functional notes
// - whole master revolutions since power-up are readable, never writable.
// - sub-revolution position in 1/65536 revolution steps is readable, never writable.
// - feedback source selects option slot 1, 2 or 3 only; drive input refused.
// - a user program may read but not write the feedback source.
// - numerator setting gives master user units per denominator revolutions.
// - denominator setting divides, so units equal revs times numerator over denominator.
// - writing either scaling setting clears position valid, and home flag for absolute encoders.
module mas_master_scaling
	import mas_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	// avalon-mm slave
	input  wire logic [`MAS_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic                   avs_program_access,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	// feedback module fraction positions, slots 1 to 3
	input  wire logic [15:0]            slot1_fraction,
	input  wire logic [15:0]            slot2_fraction,
	input  wire logic [15:0]            slot3_fraction,
	// status out
	output logic                        abs_position_ok,
	output logic                        home_reference_set,
	output logic      [31:0]            master_user_position
);

	// ==========================================================
	// state
	mas_state_type st_r;
	mas_state_type st_nxt;
	logic          fire;
	logic          wr_fire;
	logic [15:0]   sel_frac;
	logic [63:0]   product;
	logic [16:0]   rem_shift;

	function automatic logic [63:0] mag64(input logic [63:0] v);
		mag64 = v[63] ? (~v + 64'h0000_0000_0000_0001) : v;
	endfunction

	// request is answered on the cycle its waitrequest is low
	assign fire     = (avs_read | avs_write) & ~st_r.waitrequest;
	assign wr_fire  = avs_write & ~st_r.waitrequest;
	assign sel_frac = st_r.sync2[st_r.source_sel - 2'h1];
	// both operands widened first so the product keeps all 64 bits
	assign product  = 64'($signed({st_r.whole_rev, st_r.fraction})) * 64'(st_r.numerator);
	assign rem_shift = {st_r.div_rem[15:0], st_r.div_quot[63]};

	always_comb begin
		st_nxt = st_r;
		// ======================================================
		// pin synchronisers
		// limitation: a word that changes close to mclk can tear, so the slot must hold it steady
		st_nxt.sync1 = {slot3_fraction, slot2_fraction, slot1_fraction};
		st_nxt.sync2 = st_r.sync1;

		// ======================================================
		// position tracking
		st_nxt.fraction   = sel_frac;
		// synchroniser reset values are not encoder data, so wrap checks wait for a real sample
		if (st_r.frac_fill != 2'h3) begin
			st_nxt.frac_fill = st_r.frac_fill + 2'h1;
		end
		st_nxt.frac_valid = (st_r.frac_fill == 2'h3);
		if (st_r.frac_valid) begin
			if (st_r.fraction >= `MAS_WRAP_HI && sel_frac < `MAS_WRAP_LO) begin
				st_nxt.whole_rev = st_r.whole_rev + 32'sh0000_0001;
			end else if (st_r.fraction < `MAS_WRAP_LO && sel_frac >= `MAS_WRAP_HI) begin
				st_nxt.whole_rev = st_r.whole_rev - 32'sh0000_0001;
			end
		end

		// ======================================================
		// scaling divider, restoring, one quotient bit per clock
		case (st_r.div_state)
			MAS_DIV_IDLE: begin
				st_nxt.div_quot  = mag64(product);
				st_nxt.div_neg   = product[63];
				st_nxt.div_den   = st_r.denominator;
				st_nxt.div_rem   = 17'h0_0000;
				st_nxt.div_count = `MAS_DIV_STEPS;
				st_nxt.div_state = MAS_DIV_RUN;
			end
			MAS_DIV_RUN: begin
				if (rem_shift >= {1'b0, st_r.div_den}) begin
					st_nxt.div_rem = rem_shift - {1'b0, st_r.div_den};
					st_nxt.div_quot = {st_r.div_quot[62:0], 1'b1};
				end else begin
					st_nxt.div_rem = rem_shift;
					st_nxt.div_quot = {st_r.div_quot[62:0], 1'b0};
				end
				st_nxt.div_count = st_r.div_count - 7'h01;
				if (st_r.div_count == 7'h01) begin
					st_nxt.div_state = MAS_DIV_IDLE;
				end
			end
			default: begin
				st_nxt.div_state = MAS_DIV_IDLE;
			end
		endcase
		if (st_r.div_state == MAS_DIV_IDLE) begin
			st_nxt.user_pos = st_r.div_neg ? (~st_r.div_quot[31:0] + 32'h0000_0001) : st_r.div_quot[31:0];
		end

		// ======================================================
		// bus slave: one wait cycle, then answer
		st_nxt.waitrequest = ~((avs_read | avs_write) & st_r.waitrequest);
		st_nxt.readdata    = 32'h0000_0000;
		if ((avs_read | avs_write) & st_r.waitrequest) begin
			case (avs_address)
				`MAS_OFS_SOURCE:      st_nxt.readdata = {27'h0, st_r.abs_mode, 2'h0, st_r.source_sel};
				`MAS_OFS_NUMERATOR:   st_nxt.readdata = 32'(st_r.numerator);
				`MAS_OFS_DENOMINATOR: st_nxt.readdata = {16'h0000, st_r.denominator};
				`MAS_OFS_STATUS:      st_nxt.readdata = {29'h0, st_r.div_state == MAS_DIV_RUN,
				                                           st_r.home_set, st_r.abs_ok};
				`MAS_OFS_WHOLE_REV:   st_nxt.readdata = st_r.whole_rev;
				`MAS_OFS_FRACTION:    st_nxt.readdata = {16'h0000, st_r.fraction};
				`MAS_OFS_USER_POS:    st_nxt.readdata = st_r.user_pos;
				default:              st_nxt.readdata = 32'h0000_0000;
			endcase
		end
		if (wr_fire) begin
			case (avs_address)
				`MAS_OFS_SOURCE: begin
					// a program may only read the source; slot values outside 1..3 are dropped
					if (!avs_program_access) begin
						if (avs_writedata[1:0] >= `MAS_SRC_MIN) begin
							st_nxt.source_sel = avs_writedata[1:0];
							// another slot's word is a new image, not travel: no wrap from the jump
							st_nxt.frac_fill  = 2'h0;
							st_nxt.frac_valid = 1'b0;
						end
						st_nxt.abs_mode = avs_writedata[`MAS_SRC_ABS_MODE];
					end
				end
				`MAS_OFS_NUMERATOR: begin
					st_nxt.numerator = avs_writedata[15:0];
					st_nxt.abs_ok    = 1'b0;
					if (st_r.abs_mode) begin
						st_nxt.home_set = 1'b0;
					end
				end
				`MAS_OFS_DENOMINATOR: begin
					// zero would leave the scale undefined, so it is ignored
					if (avs_writedata[15:0] != 16'h0000) begin
						st_nxt.denominator = avs_writedata[15:0];
					end
					st_nxt.abs_ok = 1'b0;
					if (st_r.abs_mode) begin
						st_nxt.home_set = 1'b0;
					end
				end
				`MAS_OFS_FLAG_SET: begin
					// homing logic reports completion here
					if (avs_writedata[`MAS_STAT_ABS_OK]) begin
						st_nxt.abs_ok = 1'b1;
					end
					if (avs_writedata[`MAS_STAT_HOME_SET]) begin
						st_nxt.home_set = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r             <= '0;
			st_r.source_sel  <= `MAS_RST_SOURCE;
			st_r.numerator   <= `MAS_RST_NUMERATOR;
			st_r.denominator <= `MAS_RST_DENOMINATOR;
			st_r.div_den     <= `MAS_RST_DENOMINATOR;
			st_r.waitrequest <= 1'b1;
			st_r.div_state   <= MAS_DIV_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata         = st_r.readdata;
	assign avs_waitrequest      = st_r.waitrequest;
	assign abs_position_ok      = st_r.abs_ok;
	assign home_reference_set   = st_r.home_set;
	assign master_user_position = st_r.user_pos;

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_rev_read;
		(avs_read & st_r.waitrequest & (avs_address == `MAS_OFS_WHOLE_REV)) |=> (avs_readdata == $past(st_r.whole_rev));
	endproperty
	a_rev_read: assert property (p_rev_read) else $error("revolution read mismatch");

	property p_frac_track;
		##1 (st_r.fraction == $past(sel_frac));
	endproperty
	a_frac_track: assert property (p_frac_track) else $error("fraction not tracking source");

	property p_src_range;
		(st_r.source_sel >= `MAS_SRC_MIN) && (st_r.source_sel <= `MAS_SRC_MAX);
	endproperty
	a_src_range: assert property (p_src_range) else $error("source outside slots");

	property p_prog_ro;
		(wr_fire & avs_program_access & (avs_address == `MAS_OFS_SOURCE)) |=> $stable(st_r.source_sel);
	endproperty
	a_prog_ro: assert property (p_prog_ro) else $error("program changed source");

	property p_num_write;
		(wr_fire & (avs_address == `MAS_OFS_NUMERATOR)) |=> (st_r.numerator == $past(avs_writedata[15:0]));
	endproperty
	a_num_write: assert property (p_num_write) else $error("numerator not stored");

	property p_den_nonzero;
		(st_r.denominator != 16'h0000) && (st_r.div_den != 16'h0000);
	endproperty
	a_den_nonzero: assert property (p_den_nonzero) else $error("zero denominator");

	property p_scale_clear;
		(wr_fire & ((avs_address == `MAS_OFS_NUMERATOR) | (avs_address == `MAS_OFS_DENOMINATOR)))
			|=> !abs_position_ok ##0 (!$past(st_r.abs_mode) || !home_reference_set);
	endproperty
	a_scale_clear: assert property (p_scale_clear) else $error("flags survived scaling write");

	property p_wrap_up;
		(st_r.frac_valid && st_r.fraction >= `MAS_WRAP_HI && sel_frac < `MAS_WRAP_LO)
			|=> (st_r.whole_rev == $past(st_r.whole_rev) + 32'sh0000_0001);
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("forward wrap lost");

	property p_one_wait;
		((avs_read | avs_write) & st_r.waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer timing");

	c_wrap_up:    cover property (st_r.frac_valid && st_r.fraction >= `MAS_WRAP_HI && sel_frac < `MAS_WRAP_LO);
	c_scale_wr:   cover property (wr_fire && avs_address == `MAS_OFS_DENOMINATOR);
	c_prog_block: cover property (wr_fire && avs_program_access && avs_address == `MAS_OFS_SOURCE);
	c_div_done:   cover property (st_r.div_state == MAS_DIV_RUN && st_r.div_count == 7'h01);

endmodule

// >>> sim/mas_feedback_model.sv
// Purpose: feedback modules of the three option slots seen by the master axis block
// Assumes: one master encoder; the fraction moves by one step per clock while move is high
// Notes:   slots 2 and 3 carry distinct images of the position so the slot choice is visible
module mas_feedback_model (
	// clock
	input  wire logic        mclk,
	// motion control from the bench
	input  wire logic        move,
	input  wire logic [15:0] step,
	// fraction positions, 1/65536 rev
	output logic      [15:0] slot1_fraction,
	output logic      [15:0] slot2_fraction,
	output logic      [15:0] slot3_fraction
);
	timeunit 1ns;
	timeprecision 1ps;

	// =====================================================
	// encoder position
	// the encoder keeps its place over a device reset, so it has no reset
	logic [15:0] pos_r = 16'h0000;

	always_ff @(posedge mclk) begin
		if (move) begin
			pos_r <= pos_r + step;
		end
	end

	assign slot1_fraction = pos_r;
	assign slot2_fraction = ~pos_r;
	assign slot3_fraction = pos_r ^ 16'h5A5A;
endmodule

// >>> sim/mas_master_scaling_tb_top.sv
// Purpose: self-checking bench of the master axis scaling block
// Assumes: avalon answer comes one cycle after the request; user position settles within 150 clocks
// Notes:   motion is always stopped before the scaling is rewritten
`include "mas_regs.svh"
`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module mas_master_scaling_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// =====================================================
	// signals
	logic                   mclk;
	logic                   reset_n;
	logic [`MAS_ADDR_W-1:0] avs_address;
	logic                   avs_read;
	logic                   avs_write;
	logic [31:0]            avs_writedata;
	logic                   avs_program_access;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic [15:0]            slot1_fraction;
	logic [15:0]            slot2_fraction;
	logic [15:0]            slot3_fraction;
	logic                   abs_position_ok;
	logic                   home_reference_set;
	logic [31:0]            master_user_position;
	logic                   move;
	logic [15:0]            step;
	int                     fail_count = 0;
	int                     num_checks = 0;

	always #2 mclk = ~mclk;

	mas_master_scaling u_dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_program_access(avs_program_access),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slot1_fraction(slot1_fraction),
		.slot2_fraction(slot2_fraction), .slot3_fraction(slot3_fraction), .abs_position_ok(abs_position_ok),
		.home_reference_set(home_reference_set), .master_user_position(master_user_position));

	mas_feedback_model u_feedback (.mclk(mclk), .move(move), .step(step), .slot1_fraction(slot1_fraction),
		.slot2_fraction(slot2_fraction), .slot3_fraction(slot3_fraction));

	// =====================================================
	// tasks
	task automatic complete_run();
		if (fail_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// request held until the rising edge that sees waitrequest low; read data taken at that edge
	task automatic bus_access(input logic [4:0] a, input logic w, input logic [31:0] d, input logic p,
		output logic [31:0] r);
		int n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_program_access <= p;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			`CHECK("waitrequest", 1'b0, avs_waitrequest)
			complete_run();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic p = 1'b0);
		logic [31:0] x;
		bus_access(a, 1'b1, d, p, x);
	endtask

	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus_access(a, 1'b0, 32'h0000_0000, 1'b0, x);
		`CHECK(nm, e, x)
	endtask

	task automatic flags(input logic e_abs, input logic e_home);
		@(negedge mclk);
		`CHECK("abs_position_ok", e_abs, abs_position_ok)
		`CHECK("home_reference_set", e_home, home_reference_set)
	endtask

	task automatic run(input logic [15:0] s, input int cyc);
		@(posedge mclk);
		step <= s;
		move <= 1'b1;
		repeat (cyc) @(posedge mclk);
		move <= 1'b0;
		repeat (5) @(posedge mclk);
	endtask

	// =====================================================
	// sequence
	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_program_access = 1'b0;
		move = 1'b0;
		step = 16'h0000;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		rd_chk("source", `MAS_OFS_SOURCE, 32'h0000_0001);
		rd_chk("numerator", `MAS_OFS_NUMERATOR, 32'h0000_0001);
		rd_chk("denominator", `MAS_OFS_DENOMINATOR, 32'h0000_0001);
		rd_chk("unmapped", 5'h02, 32'h0000_0000);
		wr(`MAS_OFS_WHOLE_REV, 32'h0000_0055);
		rd_chk("whole_rev", `MAS_OFS_WHOLE_REV, 32'h0000_0000);
		wr(`MAS_OFS_FRACTION, 32'h0000_0055);
		rd_chk("fraction", `MAS_OFS_FRACTION, 32'h0000_0000);
		// absolute mode on: a scaling write drops both flags
		wr(`MAS_OFS_SOURCE, 32'h0000_0011);
		wr(`MAS_OFS_FLAG_SET, 32'h0000_0003);
		flags(1'b1, 1'b1);
		wr(`MAS_OFS_NUMERATOR, 32'h0000_0001);
		flags(1'b0, 1'b0);
		// incremental mode: a refused zero denominator still drops position valid only
		wr(`MAS_OFS_FLAG_SET, 32'h0000_0003);
		wr(`MAS_OFS_SOURCE, 32'h0000_0001);
		wr(`MAS_OFS_DENOMINATOR, 32'h0000_0000, 1'b1);
		flags(1'b0, 1'b1);
		rd_chk("denominator_zero", `MAS_OFS_DENOMINATOR, 32'h0000_0001);
		run(16'h1000, 40);
		rd_chk("whole_rev_fwd", `MAS_OFS_WHOLE_REV, 32'h0000_0002);
		rd_chk("fraction_fwd", `MAS_OFS_FRACTION, 32'h0000_8000);
		repeat (150) @(posedge mclk);
		rd_chk("user_unit", `MAS_OFS_USER_POS, 32'h0002_8000);
		wr(`MAS_OFS_NUMERATOR, 32'h0000_0003);
		wr(`MAS_OFS_DENOMINATOR, 32'h0000_0002);
		repeat (150) @(posedge mclk);
		rd_chk("user_scaled", `MAS_OFS_USER_POS, 32'h0003_C000);
		@(negedge mclk);
		`CHECK("user_port", 32'h0003_C000, master_user_position)
		run(16'hF000, 72);
		rd_chk("whole_rev_rev", `MAS_OFS_WHOLE_REV, 32'hFFFF_FFFE);
		repeat (150) @(posedge mclk);
		rd_chk("user_neg", `MAS_OFS_USER_POS, 32'hFFFD_0000);
		wr(`MAS_OFS_SOURCE, 32'h0000_0000);
		rd_chk("source_drive", `MAS_OFS_SOURCE, 32'h0000_0001);
		wr(`MAS_OFS_SOURCE, 32'h0000_0002, 1'b1);
		rd_chk("source_prog", `MAS_OFS_SOURCE, 32'h0000_0001);
		wr(`MAS_OFS_SOURCE, 32'h0000_0002);
		rd_chk("source_two", `MAS_OFS_SOURCE, 32'h0000_0002);
		repeat (5) @(posedge mclk);
		rd_chk("fraction_two", `MAS_OFS_FRACTION, 32'h0000_FFFF);
		rd_chk("whole_rev_switch", `MAS_OFS_WHOLE_REV, 32'hFFFF_FFFE);
		wr(`MAS_OFS_SOURCE, 32'h0000_0003);
		repeat (5) @(posedge mclk);
		rd_chk("fraction_three", `MAS_OFS_FRACTION, 32'h0000_5A5A);
		complete_run();
	end
endmodule
